// ### hw/rlc_consts.svh
// constants for the layer-1 configuration register group
`ifndef RLC_CONSTS_SVH
`define RLC_CONSTS_SVH
`define RLC_OFF_L1_CTRL 12'h008
`define RLC_OFF_RATE 12'h00c
`define RLC_OFF_PROT 12'h010
`define RLC_BIT_TX_EN 0
`define RLC_BIT_ROLE 1
`define RLC_BIT_FORCE 2
`define RLC_BIT_INS_EN 3
`define RLC_BIT_FILT 8
`define RLC_BIT_AUTO 9
`define RLC_BIT_RX_VALID 24
`define RLC_RX_VER_LO 16
`define RLC_RATE_MIN 5'h01
`define RLC_VER_PLAIN 8'h01
`define RLC_VER_SCRAM 8'h02
`define RLC_FILTER_HF 3'h5
`endif

// ### hw/rlc_pkg.sv
// types for the layer-1 configuration register group
package rlc_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rlc_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rlc_apb_rsp_t;
  typedef struct packed {
    logic tx_enable;
    logic slave_role;
    logic force_sync;
    logic insert_en;
    logic [4:0] line_rate;
    logic [7:0] tx_prot_ver;
  } rlc_link_cfg_t;
  typedef struct packed {
    logic [7:0] rx_byte;
    logic rx_byte_ok;
    logic hf_strobe;
  } rlc_rx_ver_t;
endpackage

// ### hw/rlc_l1_regs.sv
// layer-1 configuration and protocol version registers, apb slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "rlc_consts.svh"

// Summary of operation
// - bit 3 gates all control-table insertion; resets to zero.
// - with gate set, only entries flagged for insertion reach the frame.
// - bit 2 lets a slave try to synchronise without any master.
// - bit 1 picks role, 0 master, 1 slave; resets to build choice.
// - bit 0 enables transmission; resets to zero.
// - bits 4:0 choose the rate of the next synchronisation attempt.
// - a nonzero negotiated rate input overrides the register field.
// - rate field resets to the build-time line rate.
// - rate field writable only when rate negotiation is built in.
// - bit 24 flags a valid received protocol version byte.
// - bits 23:16 hold the received protocol version byte.
// - bit 9 enables protocol auto-negotiation, resets to one.
// - bit 8 filters received version across five hyperframes.
// - without negotiation, bits 9 and 8 read zero, unwritable.
// - bits 7:0 give transmitted version, 1 plain, 2 scrambled.
// - with auto-negotiation on, hardware rewrites the transmit version.
module rlc_l1_regs #(
  parameter bit SLAVE_ROLE_RST = 1'b0,
  parameter logic [4:0] LINE_RATE_RST = 5'h01,
  parameter bit RATE_NEGO_EN = 1'b1,
  parameter bit PROT_NEGO_EN = 1'b1,
  parameter int ENTRIES = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire rlc_pkg::rlc_apb_req_t apb_req,
  output rlc_pkg::rlc_apb_rsp_t apb_rsp,
  input wire logic [4:0] nego_rate,
  input wire rlc_pkg::rlc_rx_ver_t rx_ver,
  input wire logic scram_active,
  input wire logic [ENTRIES-1:0] entry_insert,
  output rlc_pkg::rlc_link_cfg_t link_cfg,
  output logic [ENTRIES-1:0] entry_gate
);
  import rlc_pkg::*;

  initial begin
    if (ENTRIES < 1 || ENTRIES > 256) begin
      $error("rlc_l1_regs: ENTRIES out of range");
    end
    if (LINE_RATE_RST == 5'h00) begin
      $error("rlc_l1_regs: line rate reset must be nonzero");
    end
  end

  // ==========================================================
  // state
  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic tx_en;
    logic slave;
    logic force_sync;
    logic ins_en;
    logic [4:0] rate_reg;
    logic [4:0] rate_eff;
    logic [7:0] tx_ver;
    logic auto_en;
    logic filt_en;
    logic [7:0] rx_ver;
    logic rx_valid;
    logic [7:0] cand;
    logic [2:0] cand_cnt;
    logic [ENTRIES-1:0] gate;
  } rlc_state_t;

  rlc_state_t s_q, s_d;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction

  logic setup_w;
  logic acc_w;
  assign setup_w = apb_req.psel && !apb_req.penable;
  assign acc_w = apb_req.psel && apb_req.penable && s_q.pready;

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.pready = setup_w;
    // register-bus writes, only known bits land
    if (acc_w && apb_req.pwrite) begin
      if (hit(apb_req.paddr, `RLC_OFF_L1_CTRL)) begin
        s_d.tx_en = apb_req.pwdata[`RLC_BIT_TX_EN];
        s_d.slave = apb_req.pwdata[`RLC_BIT_ROLE];
        s_d.force_sync = apb_req.pwdata[`RLC_BIT_FORCE];
        s_d.ins_en = apb_req.pwdata[`RLC_BIT_INS_EN];
      end
      if (hit(apb_req.paddr, `RLC_OFF_RATE) && RATE_NEGO_EN) begin
        s_d.rate_reg = apb_req.pwdata[4:0];
      end
      if (hit(apb_req.paddr, `RLC_OFF_PROT)) begin
        s_d.tx_ver = apb_req.pwdata[7:0];
        if (PROT_NEGO_EN) begin
          s_d.auto_en = apb_req.pwdata[`RLC_BIT_AUTO];
          s_d.filt_en = apb_req.pwdata[`RLC_BIT_FILT];
        end
      end
    end
    // negotiated rate wins while nonzero
    s_d.rate_eff = (nego_rate != 5'h00) ? nego_rate : s_d.rate_reg;
    // received version capture, optional five-hyperframe filter
    if (rx_ver.hf_strobe) begin
      if (!s_q.filt_en) begin
        s_d.rx_ver = rx_ver.rx_byte;
        s_d.rx_valid = rx_ver.rx_byte_ok;
      end else if (rx_ver.rx_byte != s_q.cand) begin
        s_d.cand = rx_ver.rx_byte;
        s_d.cand_cnt = 3'h1;
      end else if (s_q.cand_cnt < `RLC_FILTER_HF) begin
        s_d.cand_cnt = s_q.cand_cnt + 3'h1;
        if (s_d.cand_cnt == `RLC_FILTER_HF) begin
          s_d.rx_ver = rx_ver.rx_byte;
          s_d.rx_valid = rx_ver.rx_byte_ok;
        end
      end
    end
    // hardware owns transmit version while auto is on
    // a write that clears auto in the same cycle keeps its own version
    if (s_d.auto_en) begin
      s_d.tx_ver = scram_active ? `RLC_VER_SCRAM : `RLC_VER_PLAIN;
    end
    // insertion only when gate set and entry flagged
    s_d.gate = s_d.ins_en ? entry_insert : '0;
    // read data, reserved bits zero
    s_d.prdata = 32'h0;
    if (setup_w && !apb_req.pwrite) begin
      if (hit(apb_req.paddr, `RLC_OFF_L1_CTRL)) begin
        s_d.prdata[`RLC_BIT_TX_EN] = s_q.tx_en;
        s_d.prdata[`RLC_BIT_ROLE] = s_q.slave;
        s_d.prdata[`RLC_BIT_FORCE] = s_q.force_sync;
        s_d.prdata[`RLC_BIT_INS_EN] = s_q.ins_en;
      end
      if (hit(apb_req.paddr, `RLC_OFF_RATE)) begin
        s_d.prdata[4:0] = s_q.rate_reg;
      end
      if (hit(apb_req.paddr, `RLC_OFF_PROT)) begin
        s_d.prdata[7:0] = s_q.tx_ver;
        s_d.prdata[`RLC_BIT_FILT] = s_q.filt_en;
        s_d.prdata[`RLC_BIT_AUTO] = s_q.auto_en;
        s_d.prdata[`RLC_RX_VER_LO +: 8] = s_q.rx_ver;
        s_d.prdata[`RLC_BIT_RX_VALID] = s_q.rx_valid;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.slave <= SLAVE_ROLE_RST;
      s_q.rate_reg <= LINE_RATE_RST;
      s_q.rate_eff <= LINE_RATE_RST;
      s_q.tx_ver <= `RLC_VER_PLAIN;
      s_q.auto_en <= PROT_NEGO_EN;
      s_q.filt_en <= PROT_NEGO_EN;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign apb_rsp.pready = s_q.pready;
  assign apb_rsp.pslverr = 1'b0;
  assign apb_rsp.prdata = s_q.prdata;
  assign link_cfg.tx_enable = s_q.tx_en;
  assign link_cfg.slave_role = s_q.slave;
  // force only meaningful in slave role; master ignores it
  assign link_cfg.force_sync = s_q.force_sync;
  assign link_cfg.insert_en = s_q.ins_en;
  assign link_cfg.line_rate = s_q.rate_eff;
  assign link_cfg.tx_prot_ver = s_q.tx_ver;
  assign entry_gate = s_q.gate;

  // ==========================================================
  // checks
  chk_gate_off: assert property (@(posedge clock) disable iff (!rst_b)
    !s_d.ins_en |=> s_q.gate == '0)
    else $error("insertion while gate clear");
  chk_gate_sel: assert property (@(posedge clock) disable iff (!rst_b)
    s_d.ins_en |=> s_q.gate == $past(entry_insert))
    else $error("gated entries differ from flags");
  chk_rate_nego: assert property (@(posedge clock) disable iff (!rst_b)
    nego_rate != 5'h00 |=> s_q.rate_eff == $past(nego_rate))
    else $error("negotiated rate not used");
  chk_rate_reg: assert property (@(posedge clock) disable iff (!rst_b)
    nego_rate == 5'h00 |=> s_q.rate_eff == s_q.rate_reg)
    else $error("register rate not used");
  chk_rate_ro: assert property (@(posedge clock) disable iff (!rst_b)
    !RATE_NEGO_EN |=> $stable(s_q.rate_reg))
    else $error("read-only rate changed");
  chk_nego_off: assert property (@(posedge clock) disable iff (!rst_b)
    !PROT_NEGO_EN |-> !s_q.auto_en && !s_q.filt_en)
    else $error("negotiation bits set without support");
  chk_auto_ver: assert property (@(posedge clock) disable iff (!rst_b)
    s_q.auto_en ##1 s_q.auto_en |-> s_q.tx_ver == (
      $past(scram_active) ? `RLC_VER_SCRAM : `RLC_VER_PLAIN))
    else $error("auto version not applied");
  chk_filt_hold: assert property (@(posedge clock) disable iff (!rst_b)
    s_q.filt_en && s_q.cand_cnt < 3'h4 && s_q.filt_en ##1 s_q.filt_en
      |-> $stable(s_q.rx_ver) || s_q.cand_cnt == `RLC_FILTER_HF)
    else $error("filtered version taken early");
  chk_rsv_zero: assert property (@(posedge clock) disable iff (!rst_b)
    apb_rsp.prdata[31:25] == 7'h0 && apb_rsp.prdata[15:10] == 6'h0)
    else $error("reserved bits nonzero");
  chk_ready_one: assert property (@(posedge clock) disable iff (!rst_b)
    setup_w |=> apb_rsp.pready)
    else $error("no ready after setup");
  cov_write_ctrl: cover property (@(posedge clock)
    acc_w && apb_req.pwrite && hit(apb_req.paddr, `RLC_OFF_L1_CTRL));
  cov_nego_rate: cover property (@(posedge clock) nego_rate != 5'h00);
  cov_filter_take: cover property (@(posedge clock)
    s_q.filt_en && s_q.cand_cnt == `RLC_FILTER_HF);

  // ==========================================================
  // check helpers, one per register access kind
  logic wr_l1_w;
  logic wr_rate_w;
  logic wr_prot_w;
  logic rd_l1_w;
  logic rd_rate_w;
  logic rd_prot_w;
  assign wr_l1_w = acc_w && apb_req.pwrite &&
    hit(apb_req.paddr, `RLC_OFF_L1_CTRL);
  assign wr_rate_w = acc_w && apb_req.pwrite &&
    hit(apb_req.paddr, `RLC_OFF_RATE);
  assign wr_prot_w = acc_w && apb_req.pwrite &&
    hit(apb_req.paddr, `RLC_OFF_PROT);
  assign rd_l1_w = setup_w && !apb_req.pwrite &&
    hit(apb_req.paddr, `RLC_OFF_L1_CTRL);
  assign rd_rate_w = setup_w && !apb_req.pwrite &&
    hit(apb_req.paddr, `RLC_OFF_RATE);
  assign rd_prot_w = setup_w && !apb_req.pwrite &&
    hit(apb_req.paddr, `RLC_OFF_PROT);

  // ==========================================================
  // write path checks
  chk_wr_txen: assert property (@(posedge clock) disable iff (!rst_b)
    wr_l1_w |=> s_q.tx_en == $past(apb_req.pwdata[`RLC_BIT_TX_EN]))
    else $error("transmit enable write lost");
  chk_wr_role: assert property (@(posedge clock) disable iff (!rst_b)
    wr_l1_w |=> s_q.slave == $past(apb_req.pwdata[`RLC_BIT_ROLE]))
    else $error("role write lost");
  chk_wr_force: assert property (@(posedge clock) disable iff (!rst_b)
    wr_l1_w |=> s_q.force_sync == $past(apb_req.pwdata[`RLC_BIT_FORCE]))
    else $error("forced sync write lost");
  chk_wr_insen: assert property (@(posedge clock) disable iff (!rst_b)
    wr_l1_w |=> s_q.ins_en == $past(apb_req.pwdata[`RLC_BIT_INS_EN]))
    else $error("insertion gate write lost");
  chk_wr_rate: assert property (@(posedge clock) disable iff (!rst_b)
    wr_rate_w && RATE_NEGO_EN |=>
      s_q.rate_reg == $past(apb_req.pwdata[4:0]))
    else $error("rate write lost");
  chk_rate_keep: assert property (@(posedge clock) disable iff (!rst_b)
    !wr_rate_w |=> $stable(s_q.rate_reg))
    else $error("rate field changed without write");
  chk_wr_auto: assert property (@(posedge clock) disable iff (!rst_b)
    wr_prot_w && PROT_NEGO_EN |=>
      s_q.auto_en == $past(apb_req.pwdata[`RLC_BIT_AUTO]))
    else $error("auto enable write lost");
  chk_wr_filt: assert property (@(posedge clock) disable iff (!rst_b)
    wr_prot_w && PROT_NEGO_EN |=>
      s_q.filt_en == $past(apb_req.pwdata[`RLC_BIT_FILT]))
    else $error("filter enable write lost");
  chk_wr_txver: assert property (@(posedge clock) disable iff (!rst_b)
    wr_prot_w && !(PROT_NEGO_EN && apb_req.pwdata[`RLC_BIT_AUTO]) |=>
      s_q.tx_ver == $past(apb_req.pwdata[7:0]))
    else $error("transmit version write lost");
  chk_txver_keep: assert property (@(posedge clock) disable iff (!rst_b)
    !s_q.auto_en && !wr_prot_w |=> $stable(s_q.tx_ver))
    else $error("transmit version changed by itself");

  // ==========================================================
  // read path checks
  chk_rd_l1: assert property (@(posedge clock) disable iff (!rst_b)
    rd_l1_w |=> apb_rsp.prdata == {28'h0, $past(s_q.ins_en),
      $past(s_q.force_sync), $past(s_q.slave), $past(s_q.tx_en)})
    else $error("control read data wrong");
  chk_rd_rate: assert property (@(posedge clock) disable iff (!rst_b)
    rd_rate_w |=> apb_rsp.prdata == {27'h0, $past(s_q.rate_reg)})
    else $error("rate read data wrong");
  chk_rd_prot: assert property (@(posedge clock) disable iff (!rst_b)
    rd_prot_w |=> apb_rsp.prdata == {7'h0, $past(s_q.rx_valid),
      $past(s_q.rx_ver), 6'h0, $past(s_q.auto_en), $past(s_q.filt_en),
      $past(s_q.tx_ver)})
    else $error("version read data wrong");
  chk_rd_idle: assert property (@(posedge clock) disable iff (!rst_b)
    !(rd_l1_w || rd_rate_w || rd_prot_w) |=> apb_rsp.prdata == 32'h0)
    else $error("read data outside a read");
  chk_ready_only: assert property (@(posedge clock) disable iff (!rst_b)
    !setup_w |=> !apb_rsp.pready)
    else $error("ready without setup");
  chk_no_err: assert property (@(posedge clock) disable iff (!rst_b)
    apb_rsp.pslverr == 1'b0)
    else $error("error response raised");

  // ==========================================================
  // receive path checks
  chk_rx_take: assert property (@(posedge clock) disable iff (!rst_b)
    rx_ver.hf_strobe && !s_q.filt_en |=>
      s_q.rx_ver == $past(rx_ver.rx_byte))
    else $error("received version not taken");
  chk_ok_take: assert property (@(posedge clock) disable iff (!rst_b)
    rx_ver.hf_strobe && !s_q.filt_en |=>
      s_q.rx_valid == $past(rx_ver.rx_byte_ok))
    else $error("received valid flag not taken");
  chk_filt_take: assert property (@(posedge clock) disable iff (!rst_b)
    rx_ver.hf_strobe && s_q.filt_en && rx_ver.rx_byte == s_q.cand &&
      s_q.cand_cnt == 3'h4 |=> s_q.rx_ver == $past(rx_ver.rx_byte))
    else $error("filtered version not taken on fifth");
  chk_rx_keep: assert property (@(posedge clock) disable iff (!rst_b)
    !rx_ver.hf_strobe |=> $stable(s_q.rx_ver) && $stable(s_q.rx_valid))
    else $error("received version moved between strobes");

  // ==========================================================
  // reset values, checked while reset is applied
  chk_rst_l1: assert property (@(posedge clock)
    !rst_b |=> !s_q.tx_en && !s_q.ins_en && !s_q.force_sync &&
      s_q.slave == SLAVE_ROLE_RST)
    else $error("control reset value wrong");
  chk_rst_rate: assert property (@(posedge clock)
    !rst_b |=> s_q.rate_reg == LINE_RATE_RST &&
      s_q.rate_eff == LINE_RATE_RST)
    else $error("rate reset value wrong");
  chk_rst_prot: assert property (@(posedge clock)
    !rst_b |=> s_q.tx_ver == `RLC_VER_PLAIN && s_q.rx_ver == 8'h0 &&
      !s_q.rx_valid && s_q.auto_en == PROT_NEGO_EN &&
      s_q.filt_en == PROT_NEGO_EN)
    else $error("version reset value wrong");
  cov_auto_scram: cover property (@(posedge clock)
    s_q.auto_en && scram_active);
  cov_read_prot: cover property (@(posedge clock) rd_prot_w);
endmodule

// ### test/rlc_far_end.sv
// far-end link model sending the protocol version byte per hyperframe
`timescale 1ns/1ps
module rlc_far_end #(
  parameter int GAP = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [7:0] tx_byte,
  output rlc_pkg::rlc_rx_ver_t rx_ver
);
  import rlc_pkg::*;
  int cnt;
  // ==========================================
  // hyperframe pacing
  // between strobes the byte toggles so stale sampling shows up
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cnt <= 0;
      rx_ver <= '0;
    end else begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      rx_ver.hf_strobe <= (cnt == GAP - 1);
      if (cnt == GAP - 1) begin
        rx_ver.rx_byte <= tx_byte;
        rx_ver.rx_byte_ok <= (tx_byte != 8'h00);
      end else begin
        rx_ver.rx_byte <= ~rx_ver.rx_byte;
        rx_ver.rx_byte_ok <= ~rx_ver.rx_byte_ok;
      end
    end
  end
endmodule

// ### test/rlc_l1_regs_tb.sv
// self-checking bench for the layer-1 configuration registers
`timescale 1ns/1ps
`include "rlc_consts.svh"
module rlc_l1_regs_tb;
  import rlc_pkg::*;
  logic clock, rst_b, scram;
  rlc_apb_req_t req;
  rlc_apb_rsp_t rsp;
  logic [4:0] nego;
  logic [15:0] ins, gate;
  logic [7:0] far_byte;
  rlc_rx_ver_t rxv;
  rlc_link_cfg_t cfg;
  logic [31:0] rd;
  logic er;
  int n_errors, comparisons, seed, m_l1, m_rate, m_prot, m_rx;
  rlc_l1_regs rlc_l1_regs_i (.clock(clock), .rst_b(rst_b), .apb_req(req),
    .apb_rsp(rsp), .nego_rate(nego), .rx_ver(rxv), .scram_active(scram),
    .entry_insert(ins), .link_cfg(cfg), .entry_gate(gate));
  rlc_far_end #(.GAP(16)) rlc_far_end_i (.clock(clock), .rst_b(rst_b),
    .tx_byte(far_byte), .rx_ver(rxv));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ==========================================
  // reporting
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ==========================================
  // register model, auto mode derives the tx version from scrambling
  function logic [31:0] model(input logic [11:0] a);
    case (a)
      `RLC_OFF_L1_CTRL: model = m_l1;
      `RLC_OFF_RATE: model = m_rate;
      `RLC_OFF_PROT: model = m_rx | (m_prot[9] ?
        (m_prot & 'h300) | (scram ? 2 : 1) : m_prot);
      default: model = 0;
    endcase
  endfunction
  // ==========================================
  // apb master, read data taken from the access cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (rsp.pready !== 1'b1 && i < 20);
    if (rsp.pready !== 1'b1) begin
      n_errors++;
      results();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task rdchk(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
    chk(rd, model(a));
    chk(er, 1'b0);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == `RLC_OFF_L1_CTRL) m_l1 = d & 'hf;
    if (a == `RLC_OFF_RATE) m_rate = d & 'h1f;
    if (a == `RLC_OFF_PROT) m_prot = d & 'h3ff;
  endtask
  task hf(input int n);
    int i;
    repeat (n) begin
      i = 0;
      do begin
        @(posedge clock);
        i++;
      end while (rxv.hf_strobe !== 1'b1 && i < 100);
      if (rxv.hf_strobe !== 1'b1) begin
        n_errors++;
        results();
      end
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    seed = 41;
    rst_b = 1'b0;
    req = '0;
    nego = 5'h00;
    ins = 16'h0;
    scram = 1'b0;
    far_byte = 8'h00;
    m_l1 = 0;
    m_rate = 1;
    m_prot = 'h301;
    m_rx = 0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    rdchk(`RLC_OFF_L1_CTRL);
    rdchk(`RLC_OFF_RATE);
    rdchk(`RLC_OFF_PROT);
    rdchk(12'h004);
    $display("reset test done");
    wr(`RLC_OFF_L1_CTRL, 32'hffffffff);
    rdchk(`RLC_OFF_L1_CTRL);
    ins <= 16'($random(seed));
    repeat (3) @(posedge clock);
    chk({cfg.tx_enable, cfg.slave_role, cfg.force_sync, cfg.insert_en}, 4'hf);
    chk(gate, ins);
    wr(`RLC_OFF_L1_CTRL, 32'h2);
    rdchk(`RLC_OFF_L1_CTRL);
    chk(gate, 16'h0);
    $display("control test done");
    wr(`RLC_OFF_RATE, 32'hfffffff4);
    rdchk(`RLC_OFF_RATE);
    chk(cfg.line_rate, 5'h14);
    nego <= 5'($random(seed)) | 5'h01;
    repeat (3) @(posedge clock);
    chk(cfg.line_rate, nego);
    rdchk(`RLC_OFF_RATE);
    nego <= 5'h00;
    $display("rate test done");
    scram <= 1'b1;
    repeat (3) @(posedge clock);
    chk(cfg.tx_prot_ver, 8'h02);
    wr(`RLC_OFF_PROT, 32'h000002ff);
    rdchk(`RLC_OFF_PROT);
    wr(`RLC_OFF_PROT, 32'hffff0105);
    rdchk(`RLC_OFF_PROT);
    chk(cfg.tx_prot_ver, 8'h05);
    hf(1);
    far_byte <= `RLC_VER_SCRAM;
    hf(4);
    repeat (2) @(posedge clock);
    rdchk(`RLC_OFF_PROT);
    hf(1);
    repeat (2) @(posedge clock);
    m_rx = 'h1020000;
    rdchk(`RLC_OFF_PROT);
    wr(`RLC_OFF_PROT, 32'h1);
    hf(1);
    far_byte <= `RLC_VER_PLAIN;
    hf(1);
    repeat (2) @(posedge clock);
    m_rx = 'h1010000;
    rdchk(`RLC_OFF_PROT);
    $display("version test done");
    results();
  end
endmodule
